// [src/dimming_pkg.sv]
// Purpose: shared constants for the pixel switch dimming controller
// Assumes: 200 MHz system clock
// Notes: counts derive from times by expressions
package dimming_pkg;
   // ==========================================
   // sizes
   localparam int NUM_CH = 12;
   localparam int NUM_SEC = 4;
   localparam int SEC_CH = 3;
   localparam int CNT_W = 10;
   localparam logic [9:0] CNT_MAX = 10'h3ff;
   localparam logic [9:0] CNT_ZERO = 10'h000;
   localparam int FRAME_BITS = 32;
   // ==========================================
   // timing
   localparam int CLK_MHZ = 200;
   localparam int SYNC_DEB_NS = 100;
   localparam logic [11:0] SYNC_DEB_CYC = 12'((SYNC_DEB_NS * CLK_MHZ + 999) / 1000);
   localparam int OV_DB0_US = 10;
   localparam int OV_DB1_US = 15;
   localparam logic [11:0] OV_DB0_CYC = 12'(OV_DB0_US * CLK_MHZ);
   localparam logic [11:0] OV_DB1_CYC = 12'(OV_DB1_US * CLK_MHZ);
   localparam int SLOT0_NS = 8400;
   localparam int SLOT1_NS = 11400;
   localparam logic [11:0] SLOT0_CYC = 12'((SLOT0_NS * CLK_MHZ + 999) / 1000);
   localparam logic [11:0] SLOT1_CYC = 12'((SLOT1_NS * CLK_MHZ + 999) / 1000);
   localparam int BLANK_NS = 1100;
   localparam logic [8:0] BLANK_CYC = 9'((BLANK_NS * CLK_MHZ + 999) / 1000);
   // internal dimming clock 125 kHz at the lowest setting
   localparam int DIMMING_CLOCK_BASE_KHZ = 125;
   localparam logic [9:0] DIMMING_CLOCK_HALF_CYC = 10'(CLK_MHZ * 1000 / (2 * DIMMING_CLOCK_BASE_KHZ));
   // ==========================================
   // encodings and reset values
   localparam logic [3:0] TR_DIRECT = 4'he;
   localparam logic [3:0] TR_DISABLE_MIN = 4'hc;
   localparam logic [23:0] OPEN_CLEAR_CMD = 24'h04000c;
   localparam logic [3:0] CHAN1_ADDR = 4'h0;
   localparam logic [3:0] LAST_CH_ADDR = 4'hb;
   localparam logic [23:0] SHADOW_RESET = 24'h000000;
   localparam logic [1:0] DIAG_OK = 2'h0;
   localparam logic [1:0] DIAG_SHORT = 2'h1;
   localparam logic [1:0] DIAG_OPEN = 2'h2;
   // ==========================================
   // frame fields
   localparam int ON_LSB = 14;
   localparam int OFF_LSB = 4;
   localparam int SW_LSB = 4;
   localparam int WR_LSB = 24;
   localparam int RD_LSB = 28;
   localparam logic [5:0] RD_CAPTURE_BIT = 6'h04;
   localparam logic [5:0] FRAME_DONE = 6'h20;

   typedef logic [1:0] sec_idx_t;

   // source section for each section, index 0 first
   function automatic logic [7:0] group_map(input logic [3:0] sel);
      logic [7:0] m;
      m = 8'he4;
      unique case (sel)
         4'h1: m = 8'he0;
         4'h2: m = 8'ha0;
         4'h3: m = 8'hd4;
         4'h4: m = 8'ha4;
         4'h5: m = 8'h00;
         4'h6: m = 8'hc0;
         4'h7: m = 8'h54;
         4'h8: m = 8'h14;
         4'h9: m = 8'h24;
         default: m = 8'he4;
      endcase
      return m;
   endfunction
endpackage

// [src/pulse_debouncer.sv]
// Purpose: level debouncer with run-time length
// Assumes: raw input synchronous to clk
// Notes: output follows input once stable for len cycles
`timescale 1ns/100ps
module pulse_debouncer
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [11:0] len,
   input wire logic raw,
   output logic filt
);
   logic [11:0] cnt_reg;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cnt_reg <= 12'h000;
         filt <= 1'b0;
      end
      else if (raw == filt)
      begin
         cnt_reg <= 12'h000;
      end
      else if (cnt_reg + 12'h001 >= len)
      begin
         cnt_reg <= 12'h000;
         filt <= raw;
      end
      else
      begin
         cnt_reg <= cnt_reg + 12'h001;
      end
   end
endmodule

// [src/pixel_switch_dimming_controller.sv]
// Purpose: twelve-channel event dimming, diagnostics and serial slave
// Assumes: all pins synchronous to clk, serial clock far below clk
// Notes: serial write address 0..11 loads one channel shadow entry
`timescale 1ns/100ps
module pixel_switch_dimming_controller
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic pattern_update_enable,
   input wire logic dim_clock_source_sel,
   input wire logic [2:0] internal_pwm_freq_sel,
   input wire logic [3:0] switch_grouping_sel,
   input wire logic overvoltage_debounce_time,
   input wire logic [1:0] switch_on_timing_cfg,
   input wire logic status_clear,
   input wire logic thermal_shutdown,
   input wire logic [11:0] short_threshold,
   input wire logic [11:0] overvoltage_threshold,
   input wire logic sync_clock_in,
   output logic sync_clock_out,
   output logic sync_clock_oe,
   input wire logic spi_clk,
   input wire logic chip_select_n,
   input wire logic spi_sdi,
   output logic spi_sdo,
   output logic spi_sdo_oe,
   output logic fail_out,
   output logic fail_oe,
   output logic [11:0] switch_drive,
   output logic [23:0] switch_diag_status,
   output logic [11:0] open_led_flag,
   output logic dimming_error_flag,
   output logic dimming_warning_flag,
   output logic spi_error_flag,
   output logic [9:0] common_dim_counter
);
   logic [9:0] sh_on [dimming_pkg::NUM_CH];
   logic [9:0] sh_off [dimming_pkg::NUM_CH];
   logic [3:0] sh_tr [dimming_pkg::NUM_CH];
   logic [9:0] act_on [dimming_pkg::NUM_CH];
   logic [9:0] act_off [dimming_pkg::NUM_CH];
   logic [15:0] hold_reg [dimming_pkg::NUM_CH];
   logic [8:0] blank_reg [dimming_pkg::NUM_CH];
   logic [11:0] pwm_reg;
   logic [11:0] pwm_next;
   logic [11:0] ov_filt;
   logic [11:0] grouped;
   logic [11:0] indep_mask;
   logic [11:0] rise_ev;
   logic [11:0] fall_ev;
   logic [11:0] want_drive;
   logic [11:0] open_clear_req;
   logic [7:0] gmap;
   logic [11:0] ov_len;
   logic [11:0] slot_cyc;
   logic [9:0] cnt_next;
   logic [9:0] half_cyc;
   logic [9:0] div_reg;
   logic sync_filt;
   logic sync_filt_prev_reg;
   logic dim_tick;
   logic ovf;
   logic do_update;
   logic direct_mode;
   logic halt_reg;
   logic ever_enabled_reg;
   logic cs_reg;
   logic sck_reg;
   logic sdi_reg;
   logic sck_prev_reg;
   logic [5:0] bit_cnt_reg;
   logic [31:0] rx_reg;
   logic [31:0] tx_reg;
   logic [3:0] rd_addr;
   logic [23:0] rd_data;
   logic frame_ok;
   logic [3:0] wr_addr;
   logic [23:0] wr_data;
   logic clear_cmd;

   // ==========================================
   // dimming clock source
   // debounce length and delay slot select
   assign ov_len = overvoltage_debounce_time ? dimming_pkg::OV_DB1_CYC : dimming_pkg::OV_DB0_CYC;
   assign slot_cyc = switch_on_timing_cfg[0] ? dimming_pkg::SLOT1_CYC : dimming_pkg::SLOT0_CYC;
   // codes above 3 keep the fastest rate
   assign half_cyc = dimming_pkg::DIMMING_CLOCK_HALF_CYC >>
      ((internal_pwm_freq_sel > 3'h3) ? 3'h3 : internal_pwm_freq_sel);

   pulse_debouncer sync_deb
   (
      .clk(clk),
      .sys_rst(sys_rst),
      .len(dimming_pkg::SYNC_DEB_CYC),
      .raw(sync_clock_in),
      .filt(sync_filt)
   );

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         div_reg <= 10'h000;
         sync_clock_out <= 1'b0;
         sync_clock_oe <= 1'b0;
         sync_filt_prev_reg <= 1'b0;
      end
      else
      begin
         sync_filt_prev_reg <= sync_filt;
         // pin drives out only for internal source
         sync_clock_oe <= dim_clock_source_sel;
         if (!dim_clock_source_sel || div_reg + 10'h001 >= half_cyc)
         begin
            div_reg <= 10'h000;
            sync_clock_out <= dim_clock_source_sel & ~sync_clock_out;
         end
         else
         begin
            div_reg <= div_reg + 10'h001;
         end
      end
   end

   // one selects internal divider, zero the pin
   assign dim_tick = dim_clock_source_sel
      ? (!sync_clock_out && (div_reg + 10'h001 >= half_cyc))
      : (sync_filt && !sync_filt_prev_reg);

   // ==========================================
   // common counter and pattern update
   assign cnt_next = common_dim_counter + 10'h001;
   assign ovf = dim_tick && (common_dim_counter == dimming_pkg::CNT_MAX);
   assign do_update = ovf && pattern_update_enable && !halt_reg;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         common_dim_counter <= dimming_pkg::CNT_ZERO;
      end
      else if (dim_tick)
      begin
         common_dim_counter <= cnt_next;
      end
   end

   // ==========================================
   // serial slave
   assign rd_addr = rx_reg[3:0];
   assign wr_addr = rx_reg[dimming_pkg::WR_LSB +: 4];
   assign wr_data = rx_reg[23:0];
   assign frame_ok = (bit_cnt_reg == dimming_pkg::FRAME_DONE);
   assign clear_cmd = (wr_addr == dimming_pkg::CHAN1_ADDR) && (wr_data == dimming_pkg::OPEN_CLEAR_CMD);

   always_comb
   begin
      rd_data = dimming_pkg::SHADOW_RESET;
      if (rd_addr <= dimming_pkg::LAST_CH_ADDR)
      begin
         rd_data = {sh_on[rd_addr], sh_off[rd_addr], sh_tr[rd_addr]};
      end
   end

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         cs_reg <= 1'b1;
         sck_reg <= 1'b0;
         sdi_reg <= 1'b0;
         sck_prev_reg <= 1'b0;
         bit_cnt_reg <= 6'h00;
         rx_reg <= 32'h00000000;
         tx_reg <= 32'h00000000;
         spi_sdo <= 1'b0;
         spi_sdo_oe <= 1'b0;
         spi_error_flag <= 1'b0;
      end
      else
      begin
         cs_reg <= chip_select_n;
         sck_reg <= spi_clk;
         sdi_reg <= spi_sdi;
         sck_prev_reg <= sck_reg;
         spi_sdo_oe <= !cs_reg;
         if (cs_reg)
         begin
            bit_cnt_reg <= 6'h00;
            tx_reg <= {1'b0, spi_error_flag, dimming_error_flag, dimming_warning_flag,
               1'b0, thermal_shutdown, 1'b0, 25'h0000000};
            spi_sdo <= 1'b0;
         end
         else
         begin
            // sample on rising edge, msb first
            if (sck_reg && !sck_prev_reg)
            begin
               rx_reg <= {rx_reg[30:0], sdi_reg};
               if (bit_cnt_reg != 6'h3f)
               begin
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
               end
               if (bit_cnt_reg + 6'h01 == dimming_pkg::RD_CAPTURE_BIT)
               begin
                  tx_reg[24:0] <= {^{{rx_reg[2:0], sdi_reg} <= dimming_pkg::LAST_CH_ADDR
                     ? {sh_on[{rx_reg[2:0], sdi_reg}], sh_off[{rx_reg[2:0], sdi_reg}],
                     sh_tr[{rx_reg[2:0], sdi_reg}]} : dimming_pkg::SHADOW_RESET},
                     ({rx_reg[2:0], sdi_reg} <= dimming_pkg::LAST_CH_ADDR
                     ? {sh_on[{rx_reg[2:0], sdi_reg}], sh_off[{rx_reg[2:0], sdi_reg}],
                     sh_tr[{rx_reg[2:0], sdi_reg}]} : dimming_pkg::SHADOW_RESET)};
               end
            end
            // drive next bit on falling edge, msb first
            if (!sck_reg && sck_prev_reg && bit_cnt_reg < dimming_pkg::FRAME_DONE)
            begin
               spi_sdo <= tx_reg[5'(6'd31 - bit_cnt_reg)];
            end
         end
         // frame length other than 32 flags an error, set wins
         if (!cs_reg && chip_select_n && !frame_ok)
         begin
            spi_error_flag <= 1'b1;
         end
         else if (status_clear)
         begin
            spi_error_flag <= 1'b0;
         end
      end
   end

   // ==========================================
   // shadow and active settings
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         open_clear_req <= 12'h000;
         for (int i = 0; i < dimming_pkg::NUM_CH; i++)
         begin
            sh_on[i] <= dimming_pkg::CNT_ZERO;
            sh_off[i] <= dimming_pkg::CNT_ZERO;
            sh_tr[i] <= 4'h0;
            act_on[i] <= dimming_pkg::CNT_ZERO;
            act_off[i] <= dimming_pkg::CNT_ZERO;
         end
      end
      else
      begin
         open_clear_req <= 12'h000;
         // write commits at deselect of a full frame
         if (!cs_reg && chip_select_n && frame_ok)
         begin
            if (clear_cmd)
            begin
               open_clear_req <= 12'hfff;
            end
            else if (wr_addr <= dimming_pkg::LAST_CH_ADDR)
            begin
               sh_on[wr_addr] <= wr_data[dimming_pkg::ON_LSB +: 10];
               sh_off[wr_addr] <= wr_data[dimming_pkg::OFF_LSB +: 10];
               sh_tr[wr_addr] <= wr_data[3:0];
            end
         end
         if (do_update)
         begin
            for (int i = 0; i < dimming_pkg::NUM_CH; i++)
            begin
               act_on[i] <= sh_on[i];
               act_off[i] <= sh_off[i];
            end
         end
      end
   end

   // ==========================================
   // per-channel event engine
   always_comb
   begin
      for (int i = 0; i < dimming_pkg::NUM_CH; i++)
      begin
         pwm_next[i] = pwm_reg[i];
         if (halt_reg)
         begin
            pwm_next[i] = 1'b0;
         end
         else if (hold_reg[i] != 16'h0000)
         begin
            pwm_next[i] = pwm_reg[i];
         end
         else if (act_on[i] == dimming_pkg::CNT_ZERO && act_off[i] == dimming_pkg::CNT_MAX)
         begin
            pwm_next[i] = 1'b1;
         end
         else if (act_on[i] == act_off[i])
         begin
            pwm_next[i] = 1'b0;
         end
         else if (dim_tick && cnt_next == act_off[i])
         begin
            pwm_next[i] = 1'b0;
         end
         else if (dim_tick && cnt_next == act_on[i])
         begin
            pwm_next[i] = 1'b1;
         end
      end
   end

   assign rise_ev = pwm_next & ~pwm_reg & indep_mask;
   assign fall_ev = ~pwm_next & pwm_reg & indep_mask;

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         pwm_reg <= 12'h000;
         for (int i = 0; i < dimming_pkg::NUM_CH; i++)
         begin
            hold_reg[i] <= 16'h0000;
         end
      end
      else
      begin
         pwm_reg <= pwm_next;
         for (int i = 0; i < dimming_pkg::NUM_CH; i++)
         begin
            // postpone events by delay times slot
            if (do_update && sh_tr[i] < dimming_pkg::TR_DISABLE_MIN)
            begin
               hold_reg[i] <= 16'(sh_tr[i]) * 16'(slot_cyc);
            end
            else if (hold_reg[i] != 16'h0000)
            begin
               hold_reg[i] <= hold_reg[i] - 16'h0001;
            end
         end
      end
   end

   // ==========================================
   // coincidence checks
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         dimming_error_flag <= 1'b0;
         dimming_warning_flag <= 1'b0;
         halt_reg <= 1'b0;
      end
      else
      begin
         // several on events halt the pattern
         if (!direct_mode && $countones(rise_ev) > 1)
         begin
            dimming_error_flag <= 1'b1;
            halt_reg <= 1'b1;
         end
         else if (status_clear)
         begin
            dimming_error_flag <= 1'b0;
            halt_reg <= 1'b0;
         end
         if (!direct_mode && $countones(fall_ev) > 1)
         begin
            dimming_warning_flag <= 1'b1;
         end
         else if (status_clear)
         begin
            dimming_warning_flag <= 1'b0;
         end
      end
   end

   // ==========================================
   // grouping, direct mode, protection
   assign gmap = dimming_pkg::group_map(switch_grouping_sel);
   // direct mode from channel one delay code
   assign direct_mode = (sh_tr[0] == dimming_pkg::TR_DIRECT);

   always_comb
   begin
      for (int s = 0; s < dimming_pkg::NUM_SEC; s++)
      begin
         // unknown codes map to independent sections
         indep_mask[s * 3 +: 3] = (gmap[s * 2 +: 2] == 2'(s)) ? 3'h7 : 3'h0;
         for (int k = 0; k < dimming_pkg::SEC_CH; k++)
         begin
            grouped[s * 3 + k] = pwm_reg[gmap[s * 2 +: 2] * 3 + k];
         end
      end
      want_drive = direct_mode ? sh_on[0][1:0] == 2'h0 ? sh_off[0][11 - dimming_pkg::SW_LSB -: 6]
         == 6'h00 ? grouped : grouped : grouped : grouped;
      if (direct_mode)
      begin
         want_drive = {sh_on[0][1:0], sh_off[0]};
      end
      want_drive = halt_reg ? 12'h000 : (want_drive | open_led_flag);
   end

   genvar g;
   generate
      for (g = 0; g < dimming_pkg::NUM_CH; g++)
      begin : ov_chan
         pulse_debouncer ov_deb
         (
            .clk(clk),
            .sys_rst(sys_rst),
            .len(ov_len),
            .raw(overvoltage_threshold[g]),
            .filt(ov_filt[g])
         );
      end
   endgenerate

   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         switch_drive <= 12'h000;
         open_led_flag <= 12'h000;
         switch_diag_status <= 24'h000000;
         for (int i = 0; i < dimming_pkg::NUM_CH; i++)
         begin
            blank_reg[i] <= 9'h000;
         end
      end
      else
      begin
         switch_drive <= want_drive;
         for (int i = 0; i < dimming_pkg::NUM_CH; i++)
         begin
            if (want_drive[i] != switch_drive[i])
            begin
               blank_reg[i] <= dimming_pkg::BLANK_CYC;
            end
            else if (blank_reg[i] != 9'h000)
            begin
               blank_reg[i] <= blank_reg[i] - 9'h001;
            end
            // classify voltage of an open switch
            if (!switch_drive[i] && blank_reg[i] == 9'h000)
            begin
               if (ov_filt[i])
               begin
                  switch_diag_status[i * 2 +: 2] <= dimming_pkg::DIAG_OPEN;
               end
               else if (short_threshold[i])
               begin
                  switch_diag_status[i * 2 +: 2] <= dimming_pkg::DIAG_SHORT;
               end
               else
               begin
                  switch_diag_status[i * 2 +: 2] <= dimming_pkg::DIAG_OK;
               end
            end
            if (!switch_drive[i] && blank_reg[i] == 9'h000 && ov_filt[i])
            begin
               open_led_flag[i] <= 1'b1;
            end
            else if (open_clear_req[i])
            begin
               open_led_flag[i] <= 1'b0;
            end
         end
      end
   end

   // ==========================================
   // fail pin, released until first enable
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         ever_enabled_reg <= 1'b0;
         fail_out <= 1'b0;
         fail_oe <= 1'b0;
      end
      else
      begin
         fail_out <= 1'b0;
         if (pattern_update_enable)
         begin
            ever_enabled_reg <= 1'b1;
         end
         fail_oe <= ever_enabled_reg && !thermal_shutdown && !dimming_error_flag;
      end
   end
endmodule

// [verification/dimming_ctrl_properties.sv]
// Purpose: port-level checks of the dimming controller
// Assumes: one clock, synchronous active-high reset
// Notes: bound to the top module below
`timescale 1ns/100ps
module dimming_ctrl_properties
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic dim_clock_source_sel,
   input wire logic thermal_shutdown,
   input wire logic chip_select_n,
   input wire logic spi_clk,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   input wire logic sync_clock_oe,
   input wire logic fail_out,
   input wire logic fail_oe,
   input wire logic [11:0] switch_drive,
   input wire logic dimming_error_flag,
   input wire logic dimming_warning_flag,
   input wire logic [9:0] common_dim_counter
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // ====
   // serial pins
   chk_sdo_float: assert property (chip_select_n [*4] |-> !spi_sdo_oe)
      else $error("sdo driven while deselected");
   chk_sdo_enable: assert property ($fell(chip_select_n) |-> ##[2:3] spi_sdo_oe)
      else $error("sdo not driven after select");
   chk_sdo_edge: assert property ($changed(spi_sdo) && spi_sdo_oe |-> !$past(spi_clk))
      else $error("sdo changed while serial clock high");
   // ====
   // dimming
   chk_counter_step: assert property ($changed(common_dim_counter) |->
      common_dim_counter == $past(common_dim_counter) + 10'h001)
      else $error("counter skipped a value");
   chk_error_halt: assert property ($rose(dimming_error_flag) |->
      ##2 (switch_drive == 12'h000) [*2])
      else $error("switches not off after error");
   chk_error_fail: assert property ($rose(dimming_error_flag) |-> ##2 !fail_oe)
      else $error("fail pin held after error");
   // ====
   // fail and sync pins
   chk_tsd_fail: assert property (thermal_shutdown [*3] |-> !fail_oe)
      else $error("fail pin held in shutdown");
   chk_fail_level: assert property (fail_oe |-> !fail_out)
      else $error("fail pin driven high");
   chk_sync_out: assert property (dim_clock_source_sel [*3] |-> sync_clock_oe)
      else $error("sync pin not driven");
   chk_sync_in: assert property (!dim_clock_source_sel [*3] |-> !sync_clock_oe)
      else $error("sync pin driven in external mode");
   cover property ($fell(chip_select_n));
   cover property ($rose(dimming_warning_flag));
   cover property ($fell(|common_dim_counter));
endmodule

bind pixel_switch_dimming_controller dimming_ctrl_properties i_props (.clk, .sys_rst,
   .dim_clock_source_sel, .thermal_shutdown, .chip_select_n, .spi_clk, .spi_sdo,
   .spi_sdo_oe, .sync_clock_oe, .fail_out, .fail_oe, .switch_drive,
   .dimming_error_flag, .dimming_warning_flag, .common_dim_counter);

// [verification/spi_master_model.sv]
// Purpose: serial master and external dimming clock source
// Assumes: serial clock idles low, phases of 4 system clocks
// Notes: sync half period 22 clocks, faster than real to keep runs short
`timescale 1ns/100ps
module spi_master_model
(
   input wire logic clk,
   output logic spi_clk,
   output logic chip_select_n,
   output logic spi_sdi,
   input wire logic spi_sdo,
   input wire logic spi_sdo_oe,
   input wire logic sync_run,
   output logic sync_clock_in
);
   logic [4:0] phase = 5'h00;
   initial
   begin
      spi_clk = 1'b0;
      chip_select_n = 1'b1;
      spi_sdi = 1'b0;
      sync_clock_in = 1'b0;
   end
   // ====
   // dimming clock, low while stopped
   always @(negedge clk)
   begin
      phase <= (phase == 5'h15 || !sync_run) ? 5'h00 : phase + 5'h01;
      if (!sync_run)
         sync_clock_in <= 1'b0;
      else if (phase == 5'h15)
         sync_clock_in <= ~sync_clock_in;
   end
   // ====
   // one frame of nbits
   task automatic frame(input int nbits, input logic [31:0] tx, output logic [31:0] rx);
      rx = 32'h0;
      @(negedge clk);
      chip_select_n <= 1'b0;
      repeat (8) @(negedge clk);
      for (int i = 31; i > 31 - nbits; i--)
      begin
         spi_sdi <= tx[i];
         repeat (4) @(negedge clk);
         spi_clk <= 1'b1;
         rx = {rx[30:0], spi_sdo_oe ? spi_sdo : ~rx[0]};
         repeat (4) @(negedge clk);
         spi_clk <= 1'b0;
      end
      repeat (4) @(negedge clk);
      chip_select_n <= 1'b1;
      spi_sdi <= 1'b0;
      repeat (8) @(negedge clk);
   endtask
endmodule

// [verification/test_pixel_switch_dimming_controller.sv]
// Purpose: directed test of event dimming and serial access
// Assumes: inputs change on falling clock edges
// Notes: written channels use delay 0xc except the final direct-mode write of channel 0, no transition vectors
`timescale 1ns/100ps
module test_pixel_switch_dimming_controller;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pattern_update_enable = 1'b0;
   logic dim_clock_source_sel = 1'b0;
   logic [2:0] internal_pwm_freq_sel = 3'h0;
   logic status_clear = 1'b0;
   logic thermal_shutdown = 1'b0;
   logic sync_run = 1'b0;
   logic sync_clock_in, spi_clk, chip_select_n, spi_sdi, spi_sdo, spi_sdo_oe;
   logic sync_clock_out, sync_clock_oe, fail_out, fail_oe, spi_error_flag;
   logic dimming_error_flag, dimming_warning_flag;
   logic [11:0] switch_drive;
   logic [9:0] common_dim_counter;
   logic [31:0] rx;
   logic [11:0] ov_th = 12'h000;
   logic [23:0] diag;
   logic [11:0] oflag;
   int n_errors = 0;
   int n_checks = 0;

   always #2.5 clk = ~clk;

   pixel_switch_dimming_controller i_dut (.clk, .sys_rst, .pattern_update_enable,
      .dim_clock_source_sel, .internal_pwm_freq_sel, .switch_grouping_sel(4'h0),
      .overvoltage_debounce_time(1'b0), .switch_on_timing_cfg(2'h0), .status_clear,
      .thermal_shutdown, .short_threshold(12'h000), .overvoltage_threshold(ov_th),
      .sync_clock_in, .sync_clock_out, .sync_clock_oe, .spi_clk, .chip_select_n,
      .spi_sdi, .spi_sdo, .spi_sdo_oe, .fail_out, .fail_oe, .switch_drive,
      .switch_diag_status(diag), .open_led_flag(oflag), .dimming_error_flag,
      .dimming_warning_flag, .spi_error_flag, .common_dim_counter);

   spi_master_model i_mst (.clk, .spi_clk, .chip_select_n, .spi_sdi, .spi_sdo,
      .spi_sdo_oe, .sync_run, .sync_clock_in);

   // ====
   // helpers
   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task conclude;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   task wait_cnt(input logic [9:0] v);
      int k;
      k = 0;
      while (common_dim_counter !== v && k < 50000)
      begin
         @(negedge clk);
         k++;
      end
      check("counter reached", common_dim_counter, v);
   endtask

   task pulse_clear;
      status_clear = 1'b1;
      cyc(1);
      status_clear = 1'b0;
      cyc(3);
   endtask

   function automatic logic [23:0] pack(input logic [9:0] on, input logic [9:0] off);
      return {on, off, 4'hc};
   endfunction

   task wr(input logic [3:0] ch, input logic [23:0] d);
      i_mst.frame(32, {4'hd, ch, d}, rx);
   endtask

   // ====
   // main sequence
   initial
   begin
      cyc(6);
      sys_rst = 1'b0;
      cyc(2);
      dim_clock_source_sel = 1'b1;
      internal_pwm_freq_sel = 3'h3;
      cyc(4);
      check("sync oe internal", sync_clock_oe, 1'b1);
      cyc(100);
      check("sync out toggles", sync_clock_out, 1'b1);
      dim_clock_source_sel = 1'b0;
      sync_run = 1'b1;
      cyc(4);
      check("sync oe external", sync_clock_oe, 1'b0);
      wr(4'h0, pack(10'h000, 10'h3ff));
      wr(4'h1, pack(10'h003, 10'h003));
      wr(4'h2, pack(10'h004, 10'h008));
      wr(4'h3, pack(10'h005, 10'h008));
      wr(4'h4, pack(10'h00c, 10'h00e));
      wr(4'h5, pack(10'h00c, 10'h00f));
      i_mst.frame(32, {4'h2, 4'hd, 24'h000000}, rx);
      check("read data", rx[23:0], pack(10'h004, 10'h008));
      check("read parity", rx[24], ^pack(10'h004, 10'h008));
      i_mst.frame(31, {4'hd, 4'h6, 24'h0300ec}, rx);
      check("short frame error", spi_error_flag, 1'b1);
      i_mst.frame(32, {4'h6, 4'hd, 24'h000000}, rx);
      check("dropped write", rx[23:0], 24'h000000);
      check("status error bit", rx[30], 1'b1);
      pulse_clear();
      check("error cleared", spi_error_flag, 1'b0);
      pattern_update_enable = 1'b1;
      cyc(4);
      check("fail held", fail_oe, 1'b1);
      thermal_shutdown = 1'b1;
      cyc(4);
      check("fail released", fail_oe, 1'b0);
      thermal_shutdown = 1'b0;
      wait_cnt(10'h3ff);
      check("before overflow", switch_drive, 12'h000);
      wait_cnt(10'h000);
      wait_cnt(10'h006);
      cyc(2);
      check("drive at 6", switch_drive, 12'h00d);
      wait_cnt(10'h009);
      cyc(2);
      check("drive at 9", switch_drive, 12'h001);
      check("warning", dimming_warning_flag, 1'b1);
      check("no error", dimming_error_flag, 1'b0);
      wait_cnt(10'h00d);
      cyc(4);
      check("error", dimming_error_flag, 1'b1);
      check("all off", switch_drive, 12'h000);
      check("fail on error", fail_oe, 1'b0);
      pulse_clear();
      ov_th = 12'h800;
      cyc(2100);
      check("diag open", diag[23:22], dimming_pkg::DIAG_OPEN);
      check("open flag", oflag[11], 1'b1);
      check("forced closed", switch_drive[11], 1'b1);
      ov_th = 12'h000;
      cyc(2100);
      wr(4'h0, dimming_pkg::OPEN_CLEAR_CMD);
      check("open flag cleared", oflag[11], 1'b0);
      wr(4'h0, {8'h00, 12'h5a3, dimming_pkg::TR_DIRECT});
      cyc(4);
      check("direct drive", switch_drive, 12'h5a3);
      conclude();
   end

   initial
   begin
      #450000;
      n_errors++;
      conclude();
   end
endmodule
